//--- src/alu_addr_core.sv
// alu flag register, operand address generation and indirect pointers
// assumes a decoder that presents address fields, then operands, per instruction
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps

// Operation
// - flag-affecting ops override writes to flag bits
// - clearing flag register sets zero flag only
// - flag register top three bits read zero
// - negative flag follows result bit seven
// - overflow flag marks wrong signed sign change
// - zero flag marks zero result
// - half carry from low nibble on add/sub
// - carry from top bit on add/sub
// - subtract adds complement, carries mean not-borrow
// - rotates load half carry and carry
// - direct address from opcode low byte
// - access bit picks bank or access bank
// - full twelve-bit address ignores bank select
// - destination bit picks file or accumulator
// - jump target from instruction literal fields
// - pointers reachable by direct access too
// - post-decrement, post-increment and pre-increment operands auto-modify pointer
// - literal offset mode only when extended
// - top counter bit only in test mode
// - pointer is twelve bits from pair
// - indirect operand addresses via pointer, no bank
// - post_decrement_operand, post_increment_operand, pre_increment_operand, accumulator offset semantics
// - pointer steps carry full width, no flags
module alu_addr_core #(
  parameter int NPTR = 3
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // configuration
  input wire logic ext_isa_enable_in,
  input wire logic test_mode_in,
  // address stage
  input wire logic addr_req_in,
  input wire logic [7:0] file_addr_in,
  input wire logic access_in,
  input wire logic full_addr_valid_in,
  input wire logic [11:0] full_addr_in,
  input wire logic [7:0] w_in,
  output logic [11:0] data_addr_out,
  output logic addr_valid_out,
  // execute stage
  input wire logic exec_in,
  input wire alu_addr_pkg::alu_op_t alu_op_in,
  input wire logic [7:0] operand_a_in,
  input wire logic [7:0] operand_b_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic dest_in,
  output logic [7:0] result_out,
  output logic w_write_out,
  output logic file_write_out,
  output logic [11:0] wb_addr_out,
  output logic [7:0] flags_out,
  // program target
  input wire logic jump_in,
  input wire logic [7:0] jump_lo_in,
  input wire logic [11:0] jump_hi_in,
  output logic [19:0] jump_target_out,
  output logic pc_top_bit_out
);
  import alu_addr_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [FLAG_W-1:0] flags;
  logic [3:0] bank;
  logic [11:0] ptr [NPTR];
  logic [FLAG_W-1:0] next_flags;

  // --------------------------------------------------------------------
  // merged software write: register port first, then file write-back
  // --------------------------------------------------------------------
  logic sw_wr;
  logic [11:0] sw_addr;
  logic [7:0] sw_data;
  logic [7:0] res;

  always_comb
  begin
    sw_wr = reg_wr_in || (exec_in && dest_in);
    sw_addr = reg_wr_in ? reg_addr_in : data_addr_out;
    sw_data = reg_wr_in ? reg_wdata_in : res;
  end

  // --------------------------------------------------------------------
  // direct address
  // --------------------------------------------------------------------
  logic [11:0] direct_addr;

  always_comb
  begin
    if (full_addr_valid_in)
      direct_addr = full_addr_in;
    else if (access_in)
      direct_addr = {bank, file_addr_in};
    else if (ext_isa_enable_in && file_addr_in <= LIT_OFS_MAX)
      direct_addr = ptr[LIT_OFS_PTR] + {4'h0, file_addr_in};
    else if (file_addr_in >= ACCESS_SPLIT)
      direct_addr = {4'hf, file_addr_in};
    else
      direct_addr = {4'h0, file_addr_in};
  end

  // --------------------------------------------------------------------
  // pointers and their virtual operands
  // --------------------------------------------------------------------
  logic [NPTR-1:0] hit;
  logic [11:0] vaddr [NPTR];
  logic [11:0] auto_ptr [NPTR];
  logic [2:0] vsel;

  assign vsel = direct_addr[2:0];

  for (genvar g = 0; g < NPTR; g++)
  begin : g_ptr
    localparam logic [11:0] VB = VIRT_BASE - 12'(g) * VIRT_STEP;
    localparam logic [11:0] LO = PTR_BASE + 12'(2 * g);
    localparam logic [11:0] HI = LO + 12'h001;

    // bank and access bit play no part once the operand is virtual
    assign hit[g] = (direct_addr[11:3] == VB[11:3]) && (vsel <= V_ACCUMULATOR_OFFSET_OPERAND);

    always_comb
    begin
      case (vsel)
        V_PRE_INCREMENT_OPERAND: vaddr[g] = ptr[g] + 12'h001;
        V_ACCUMULATOR_OFFSET_OPERAND: vaddr[g] = ptr[g] + {{4{w_in[7]}}, w_in};
        default: vaddr[g] = ptr[g];
      endcase
      case (vsel)
        V_POST_DECREMENT_OPERAND: auto_ptr[g] = ptr[g] - 12'h001;
        V_POST_INCREMENT_OPERAND: auto_ptr[g] = ptr[g] + 12'h001;
        V_PRE_INCREMENT_OPERAND: auto_ptr[g] = ptr[g] + 12'h001;
        default: auto_ptr[g] = ptr[g];
      endcase
    end

    // a direct write lands unmodified, even through a stepping operand
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
        ptr[g] <= PTR_RST;
      else if (ce_in)
      begin
        if (sw_wr && sw_addr == LO)
          ptr[g] <= {ptr[g][11:8], sw_data};
        else if (sw_wr && sw_addr == HI)
          ptr[g] <= {sw_data[3:0], ptr[g][7:0]};
        else if (addr_req_in && hit[g])
          ptr[g] <= auto_ptr[g];
      end
    end
  end

  logic [11:0] eff_addr;

  always_comb
  begin
    eff_addr = direct_addr;
    for (int i = 0; i < NPTR; i++)
      if (hit[i])
        eff_addr = vaddr[i];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      data_addr_out <= 12'h000;
      addr_valid_out <= 1'h0;
    end
    else if (ce_in)
    begin
      if (addr_req_in)
        data_addr_out <= eff_addr;
      addr_valid_out <= addr_req_in;
    end
  end

  // --------------------------------------------------------------------
  // alu and flag computation
  // --------------------------------------------------------------------
  logic sub;
  logic [7:0] b_eff;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [FLAG_W-1:0] calc;
  logic [FLAG_W-1:0] affect;
  logic [7:0] bit_mask;

  always_comb
  begin
    sub = (alu_op_in == OP_SUB);
    b_eff = sub ? ~operand_b_in : operand_b_in;
    sum = {1'h0, operand_a_in} + {1'h0, b_eff} + {8'h00, sub};
    nib = {1'h0, operand_a_in[3:0]} + {1'h0, b_eff[3:0]} + {4'h0, sub};
    bit_mask = 8'h01 << bit_sel_in;
    calc = MASK_NONE;
    calc[FLAG_C] = sum[8];
    calc[FLAG_DC] = nib[4];
    calc[FLAG_OV] = (operand_a_in[7] == b_eff[7]) && (sum[7] != operand_a_in[7]);
    res = operand_a_in;
    affect = MASK_NONE;
    case (alu_op_in)
      OP_ADD, OP_SUB:
      begin
        res = sum[7:0];
        affect = MASK_ALL;
      end
      OP_AND:
      begin
        res = operand_a_in & operand_b_in;
        affect = MASK_ZN;
      end
      OP_IOR:
      begin
        res = operand_a_in | operand_b_in;
        affect = MASK_ZN;
      end
      OP_XOR:
      begin
        res = operand_a_in ^ operand_b_in;
        affect = MASK_ZN;
      end
      OP_CLR:
      begin
        res = 8'h00;
        affect = MASK_Z;
      end
      OP_RLC:
      begin
        res = {operand_a_in[6:0], flags[FLAG_C]};
        calc[FLAG_C] = operand_a_in[7];
        calc[FLAG_DC] = operand_a_in[3];
        affect = MASK_ROT;
      end
      OP_RRC:
      begin
        res = {flags[FLAG_C], operand_a_in[7:1]};
        calc[FLAG_C] = operand_a_in[0];
        calc[FLAG_DC] = operand_a_in[4];
        affect = MASK_ROT;
      end
      OP_SWAP: res = {operand_a_in[3:0], operand_a_in[7:4]};
      OP_MOV: res = operand_a_in;
      OP_BSET: res = operand_a_in | bit_mask;
      OP_BCLR: res = operand_a_in & ~bit_mask;
      default:
      begin
        res = operand_a_in;
        affect = MASK_NONE;
      end
    endcase
    calc[FLAG_Z] = (res == 8'h00);
    calc[FLAG_N] = res[7];
  end

  // --------------------------------------------------------------------
  // flag register: hardware flag updates win over any write to them
  // --------------------------------------------------------------------
  always_comb
  begin
    next_flags = flags;
    // a flag-changing op aimed at this register may not write any of the five flags
    if (sw_wr && sw_addr == FLAGS_ADDR && (reg_wr_in || affect == MASK_NONE))
      next_flags = sw_data[FLAG_W-1:0];
    if (exec_in)
      next_flags = (next_flags & ~affect) | (calc & affect);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      flags <= FLAGS_RST;
    else if (ce_in)
      flags <= next_flags;
  end

  assign flags_out = {3'h0, flags};

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      bank <= BANK_RST;
    else if (ce_in && sw_wr && sw_addr == BANK_ADDR)
      bank <= sw_data[3:0];
  end

  // leaving test mode drops the bit so normal code never sees it
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      pc_top_bit_out <= 1'h0;
    else if (ce_in)
    begin
      if (!test_mode_in)
        pc_top_bit_out <= 1'h0;
      else if (sw_wr && sw_addr == PC_TOP_ADDR)
        pc_top_bit_out <= sw_data[0];
    end
  end

  // --------------------------------------------------------------------
  // execute outputs and program target
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      result_out <= 8'h00;
      w_write_out <= 1'h0;
      file_write_out <= 1'h0;
      wb_addr_out <= 12'h000;
      jump_target_out <= 20'h00000;
    end
    else if (ce_in)
    begin
      if (exec_in)
      begin
        result_out <= res;
        wb_addr_out <= data_addr_out;
      end
      w_write_out <= exec_in && !dest_in;
      file_write_out <= exec_in && dest_in;
      if (jump_in)
        jump_target_out <= {jump_hi_in, jump_lo_in};
    end
  end

  // --------------------------------------------------------------------
  // register port read
  // --------------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (reg_addr_in == FLAGS_ADDR)
      rd_mux = {3'h0, flags};
    else if (reg_addr_in == BANK_ADDR)
      rd_mux = {4'h0, bank};
    else if (reg_addr_in == PC_TOP_ADDR)
      rd_mux = {7'h00, pc_top_bit_out};
    for (int i = 0; i < NPTR; i++)
    begin
      if (reg_addr_in == PTR_BASE + 12'(2 * i))
        rd_mux = ptr[i][7:0];
      if (reg_addr_in == PTR_BASE + 12'(2 * i) + 12'h001)
        rd_mux = {4'h0, ptr[i][11:8]};
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (ce_in)
      reg_rdata_out <= reg_rd_in ? rd_mux : 8'h00;
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_flag_top_zero: assert property (
    ce_in && reg_rd_in && reg_addr_in == FLAGS_ADDR
    |=> reg_rdata_out == {3'h0, $past(flags_out[4:0])})
    else $error("flag register read back wrong");

  chk_zero_flag: assert property (
    ce_in && exec_in && alu_op_in == OP_XOR |=> flags_out[FLAG_Z] == (result_out == 8'h00))
    else $error("zero flag disagrees with result");

  chk_neg_flag: assert property (
    ce_in && exec_in && alu_op_in == OP_ADD |=> flags_out[FLAG_N] == result_out[7])
    else $error("negative flag disagrees with result");

  chk_clr_flags: assert property (
    ce_in && exec_in && alu_op_in == OP_CLR && dest_in && !reg_wr_in &&
    data_addr_out == FLAGS_ADDR
    |=> flags_out == {3'h0, $past(flags[4:3]), 1'h1, $past(flags[1:0])})
    else $error("clear of flag register gave wrong value");

  chk_add_carry: assert property (
    ce_in && exec_in && alu_op_in == OP_ADD
    |=> flags_out[FLAG_C] == (({1'h0, $past(operand_a_in)} + {1'h0, $past(operand_b_in)}) > 9'h0ff))
    else $error("add carry wrong");

  chk_sub_borrow: assert property (
    ce_in && exec_in && alu_op_in == OP_SUB
    |=> flags_out[FLAG_C] == ($past(operand_a_in) >= $past(operand_b_in)))
    else $error("subtract carry is not inverted borrow");

  chk_bank_addr: assert property (
    ce_in && addr_req_in && access_in && !full_addr_valid_in && bank != 4'hf
    |=> addr_valid_out && data_addr_out == {$past(bank), $past(file_addr_in)})
    else $error("banked address wrong");

  chk_full_addr: assert property (
    ce_in && addr_req_in && full_addr_valid_in && full_addr_in < FLAGS_ADDR
    |=> data_addr_out == $past(full_addr_in))
    else $error("full address not used as given");

  chk_post_increment_operand_ptr: assert property (
    ce_in && addr_req_in && hit[0] && vsel == V_POST_INCREMENT_OPERAND && !sw_wr
    |=> data_addr_out == $past(ptr[0]) && ptr[0] == $past(ptr[0]) + 12'h001)
    else $error("post increment pointer wrong");

  chk_dest_select: assert property (
    ce_in && exec_in |=> w_write_out == !$past(dest_in) && file_write_out == $past(dest_in))
    else $error("destination select wrong");

endmodule // alu_addr_core

//--- pkg/alu_addr_pkg.sv
// alu flag layout, operation codes and data-space map of the core datapath
// assumes the decoder drives operation codes from alu_op_t
package alu_addr_pkg;

  // --------------------------------------------------------------------
  // flag register layout
  // --------------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int FLAG_W = 5;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
  localparam logic [FLAG_W-1:0] MASK_ALL = 5'h1f;
  localparam logic [FLAG_W-1:0] MASK_ZN = 5'h14;
  localparam logic [FLAG_W-1:0] MASK_Z = 5'h04;
  localparam logic [FLAG_W-1:0] MASK_ROT = 5'h17;
  localparam logic [FLAG_W-1:0] MASK_NONE = 5'h00;

  // --------------------------------------------------------------------
  // operations
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_AND = 4'h2,
    OP_IOR = 4'h3,
    OP_XOR = 4'h4,
    OP_CLR = 4'h5,
    OP_RLC = 4'h6,
    OP_RRC = 4'h7,
    OP_SWAP = 4'h8,
    OP_MOV = 4'h9,
    OP_BSET = 4'ha,
    OP_BCLR = 4'hb
  } alu_op_t;

  // --------------------------------------------------------------------
  // data-space map, also the register port map
  // --------------------------------------------------------------------
  localparam logic [11:0] FLAGS_ADDR = 12'hfd0;
  localparam logic [11:0] BANK_ADDR = 12'hfd1;
  localparam logic [11:0] PTR_BASE = 12'hfd2;
  localparam logic [11:0] PC_TOP_ADDR = 12'hfd8;
  localparam logic [11:0] VIRT_BASE = 12'hff0;
  localparam logic [11:0] VIRT_STEP = 12'h008;
  localparam logic [2:0] V_IND = 3'h0;
  localparam logic [2:0] V_POST_DECREMENT_OPERAND = 3'h1;
  localparam logic [2:0] V_POST_INCREMENT_OPERAND = 3'h2;
  localparam logic [2:0] V_PRE_INCREMENT_OPERAND = 3'h3;
  localparam logic [2:0] V_ACCUMULATOR_OFFSET_OPERAND = 3'h4;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] LIT_OFS_MAX = 8'h5f;
  localparam int LIT_OFS_PTR = 2;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [11:0] PTR_RST = 12'h000;

endpackage

//--- tb/alu_decoder_model.sv
// decoder-side model: launches address and execute requests into the core
// assumes one clock; each request is a one-cycle pulse launched after a rising edge
`timescale 1ns/1ps

module alu_decoder_model
(
  // clock
  input wire logic clk_in,
  // address stage
  output logic addr_req_out,
  output logic [7:0] file_addr_out,
  output logic access_out,
  output logic full_addr_valid_out,
  output logic [11:0] full_addr_out,
  output logic [7:0] w_out,
  // execute stage
  output logic exec_out,
  output alu_addr_pkg::alu_op_t alu_op_out,
  output logic [7:0] operand_a_out,
  output logic [7:0] operand_b_out,
  output logic [2:0] bit_sel_out,
  output logic dest_out
);
  import alu_addr_pkg::*;

  initial
  begin
    addr_req_out = 1'h0;
    file_addr_out = 8'h00;
    access_out = 1'h0;
    full_addr_valid_out = 1'h0;
    full_addr_out = 12'h000;
    w_out = 8'h00;
    exec_out = 1'h0;
    alu_op_out = OP_MOV;
    operand_a_out = 8'h00;
    operand_b_out = 8'h00;
    bit_sel_out = 3'h0;
    dest_out = 1'h0;
  end

  // ----
  // requests; released address and operand values are inverted so stale values never look valid
  // ----
  task automatic resolve(input logic [7:0] f, input logic a, input logic fv,
                         input logic [11:0] fa, input logic [7:0] w);
    @(posedge clk_in);
    addr_req_out <= 1'h1;
    file_addr_out <= f;
    access_out <= a;
    full_addr_valid_out <= fv;
    full_addr_out <= fa;
    w_out <= w;
    @(posedge clk_in);
    addr_req_out <= 1'h0;
    file_addr_out <= ~f;
    full_addr_out <= ~fa;
  endtask

  task automatic execute(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                         input logic [2:0] bs, input logic d);
    @(posedge clk_in);
    exec_out <= 1'h1;
    alu_op_out <= op;
    operand_a_out <= a;
    operand_b_out <= b;
    bit_sel_out <= bs;
    dest_out <= d;
    @(posedge clk_in);
    exec_out <= 1'h0;
    operand_a_out <= ~a;
    operand_b_out <= ~b;
  endtask
endmodule // alu_decoder_model

//--- tb/test_alu_flags_and_data_addressing.sv
// self-checking bench for the flag register and operand address generation
// assumes the decoder model drives the address and execute stages of the core
`timescale 1ns/1ps

module test_alu_flags_and_data_addressing;
  import alu_addr_pkg::*;

  typedef struct packed {
    alu_op_t op; logic [7:0] a; logic [7:0] b; logic [2:0] bs; logic d;
    logic [7:0] res; logic [4:0] fl;
  } alu_row_t;
  typedef struct packed {
    logic ext; logic acc; logic fv; logic [11:0] fa; logic [7:0] f; logic [7:0] w;
    logic [11:0] exp;
  } addr_row_t;

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic [11:0] r_addr = 12'h000;
  logic [7:0] r_wdata = 8'h00;
  logic r_wr = 1'h0;
  logic r_rd = 1'h0;
  logic ext = 1'h0;
  logic tmode = 1'h0;
  logic jmp = 1'h0;
  logic [7:0] jlo = 8'h00;
  logic [11:0] jhi = 12'h000;
  logic [7:0] r_rdata, fa, w, oa, ob, res, flg;
  logic [11:0] fulla, daddr, wb_addr;
  logic [19:0] jtgt;
  logic [2:0] bs;
  logic areq, acc, fav, aval, ex, dst, w_wr, f_wr, pctop;
  alu_op_t op;
  int err_total = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  alu_addr_core #(.NPTR(3)) dut_u (
    .clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .reg_addr_in(r_addr), .reg_wdata_in(r_wdata), .reg_wr_in(r_wr),
    .reg_rd_in(r_rd), .reg_rdata_out(r_rdata),
    .ext_isa_enable_in(ext), .test_mode_in(tmode),
    .addr_req_in(areq), .file_addr_in(fa), .access_in(acc),
    .full_addr_valid_in(fav), .full_addr_in(fulla), .w_in(w),
    .data_addr_out(daddr), .addr_valid_out(aval),
    .exec_in(ex), .alu_op_in(op), .operand_a_in(oa), .operand_b_in(ob),
    .bit_sel_in(bs), .dest_in(dst), .result_out(res), .w_write_out(w_wr),
    .file_write_out(f_wr), .wb_addr_out(wb_addr), .flags_out(flg),
    .jump_in(jmp), .jump_lo_in(jlo), .jump_hi_in(jhi),
    .jump_target_out(jtgt), .pc_top_bit_out(pctop)
  );

  alu_decoder_model dec_u (
    .clk_in(clk), .addr_req_out(areq), .file_addr_out(fa), .access_out(acc),
    .full_addr_valid_out(fav), .full_addr_out(fulla), .w_out(w),
    .exec_out(ex), .alu_op_out(op), .operand_a_out(oa), .operand_b_out(ob),
    .bit_sel_out(bs), .dest_out(dst)
  );

  // ----
  // helpers
  // ----
  task automatic check(input string n, input logic [19:0] e, input logic [19:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    r_addr <= a;
    r_wdata <= d;
    r_wr <= 1'h1;
    @(posedge clk);
    r_wr <= 1'h0;
  endtask

  task automatic reg_check(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    r_addr <= a;
    r_rd <= 1'h1;
    @(posedge clk);
    r_rd <= 1'h0;
    #1 check("reg_rdata", {12'h000, e}, {12'h000, r_rdata});
  endtask

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----
  // tables; flag field is {n, ov, z, dc, c}, rows run in order
  // ----
  alu_row_t alu_rows [16] = '{
    '{OP_ADD, 8'h80, 8'h80, 3'h0, 1'h0, 8'h00, 5'h0d},
    '{OP_ADD, 8'h0f, 8'h01, 3'h0, 1'h1, 8'h10, 5'h02},
    '{OP_ADD, 8'h7f, 8'h01, 3'h0, 1'h0, 8'h80, 5'h1a},
    '{OP_SUB, 8'h05, 8'h03, 3'h0, 1'h1, 8'h02, 5'h03},
    '{OP_SUB, 8'h03, 8'h05, 3'h0, 1'h0, 8'hfe, 5'h10},
    '{OP_SUB, 8'h80, 8'h01, 3'h0, 1'h1, 8'h7f, 5'h09},
    '{OP_AND, 8'hf0, 8'h0f, 3'h0, 1'h0, 8'h00, 5'h0d},
    '{OP_XOR, 8'ha5, 8'hff, 3'h0, 1'h1, 8'h5a, 5'h09},
    '{OP_IOR, 8'h80, 8'h01, 3'h0, 1'h0, 8'h81, 5'h19},
    '{OP_CLR, 8'h55, 8'h00, 3'h0, 1'h1, 8'h00, 5'h1d},
    '{OP_RLC, 8'h85, 8'h00, 3'h0, 1'h0, 8'h0b, 5'h09},
    '{OP_RRC, 8'h11, 8'h00, 3'h0, 1'h1, 8'h88, 5'h1b},
    '{OP_SWAP, 8'ha5, 8'h00, 3'h0, 1'h0, 8'h5a, 5'h1b},
    '{OP_MOV, 8'h3c, 8'h00, 3'h0, 1'h1, 8'h3c, 5'h1b},
    '{OP_BSET, 8'h00, 8'h00, 3'h3, 1'h0, 8'h08, 5'h1b},
    '{OP_BCLR, 8'hff, 8'h00, 3'h0, 1'h1, 8'hfe, 5'h1b}
  };
  addr_row_t addr_rows [13] = '{
    '{1'h0, 1'h1, 1'h0, 12'h000, 8'h45, 8'h00, 12'h345},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'h45, 8'h00, 12'h045},
    '{1'h0, 1'h1, 1'h1, 12'habc, 8'h45, 8'h00, 12'habc},
    '{1'h1, 1'h0, 1'h0, 12'h000, 8'h10, 8'h00, 12'h133},
    '{1'h1, 1'h0, 1'h0, 12'h000, 8'h5f, 8'h00, 12'h182},
    '{1'h1, 1'h0, 1'h0, 12'h000, 8'h60, 8'h00, 12'hf60},
    '{1'h1, 1'h1, 1'h0, 12'h000, 8'h10, 8'h00, 12'h310},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'hf2, 8'h00, 12'h1ff},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'hf1, 8'h00, 12'h200},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'hf3, 8'h00, 12'h200},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'hf0, 8'h00, 12'h200},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'hf4, 8'hfe, 12'h1fe},
    '{1'h0, 1'h0, 1'h0, 12'h000, 8'he9, 8'h00, 12'h000}
  };

  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    #1 check("flags_after_reset", 20'h0, {12'h000, flg});
    reg_check(BANK_ADDR, 8'h00);
    foreach (alu_rows[i])
    begin
      dec_u.execute(alu_rows[i].op, alu_rows[i].a, alu_rows[i].b, alu_rows[i].bs,
                    alu_rows[i].d);
      #1 check("result", {12'h000, alu_rows[i].res}, {12'h000, res});
      check("flags", {15'h0, alu_rows[i].fl}, {12'h000, flg});
      check("wr_pulses", {18'h0, alu_rows[i].d, ~alu_rows[i].d}, {18'h0, f_wr, w_wr});
    end
    reg_write(BANK_ADDR, 8'h03);
    reg_write(PTR_BASE, 8'hff);
    reg_write(PTR_BASE + 12'h001, 8'hf1);
    reg_write(PTR_BASE + 12'h004, 8'h23);
    reg_write(PTR_BASE + 12'h005, 8'h01);
    reg_check(PTR_BASE + 12'h001, 8'h01);
    foreach (addr_rows[i])
    begin
      @(posedge clk);
      ext <= addr_rows[i].ext;
      dec_u.resolve(addr_rows[i].f, addr_rows[i].acc, addr_rows[i].fv, addr_rows[i].fa,
                    addr_rows[i].w);
      #1 check("data_addr", {8'h00, addr_rows[i].exp}, {8'h00, daddr});
      check("addr_valid", 20'h1, {19'h0, aval});
    end
    check("flags_kept", 20'h1b, {12'h000, flg});
    reg_check(PTR_BASE, 8'h00);
    reg_check(PTR_BASE + 12'h001, 8'h02);
    reg_check(PTR_BASE + 12'h002, 8'hff);
    reg_check(PTR_BASE + 12'h003, 8'h0f);
    reg_write(FLAGS_ADDR, 8'hff);
    reg_check(FLAGS_ADDR, 8'h1f);
    reg_write(FLAGS_ADDR, 8'h0a);
    dec_u.resolve(8'hd0, 1'h0, 1'h0, 12'h000, 8'h00);
    dec_u.execute(OP_CLR, 8'h00, 8'h00, 3'h0, 1'h1);
    #1 check("wb_addr", 20'h00fd0, {8'h00, wb_addr});
    reg_check(FLAGS_ADDR, 8'h0e);
    dec_u.execute(OP_ADD, 8'h00, 8'h01, 3'h0, 1'h1);
    reg_check(FLAGS_ADDR, 8'h00);
    // flag bits are altered only with an op that leaves them alone
    dec_u.execute(OP_BSET, 8'h00, 8'h00, 3'h4, 1'h1);
    reg_check(FLAGS_ADDR, 8'h10);
    reg_check(12'h100, 8'h00);
    @(posedge clk);
    jmp <= 1'h1;
    jlo <= 8'h34;
    jhi <= 12'habc;
    @(posedge clk);
    jmp <= 1'h0;
    #1 check("jump_target", 20'habc34, jtgt);
    reg_write(PC_TOP_ADDR, 8'h01);
    #1 check("pc_top_normal", 20'h0, {19'h0, pctop});
    @(posedge clk);
    tmode <= 1'h1;
    reg_write(PC_TOP_ADDR, 8'h01);
    #1 check("pc_top_test", 20'h1, {19'h0, pctop});
    @(posedge clk);
    tmode <= 1'h0;
    @(posedge clk);
    #1 check("pc_top_forced", 20'h0, {19'h0, pctop});
    // a low enable freezes state even under a write strobe
    @(posedge clk);
    ce <= 1'h0;
    reg_write(BANK_ADDR, 8'h05);
    ce <= 1'h1;
    reg_check(BANK_ADDR, 8'h03);
    // a second reset in mid-run clears flags and pointers again
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    #1 check("flags_rerun", 20'h0, {12'h000, flg});
    reg_check(PTR_BASE + 12'h001, 8'h00);
    wrap_up();
  end

  // hang guard, far beyond the hundred and fifty or so cycles the sequence needs
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule // test_alu_flags_and_data_addressing
